/* rtl/lpi_pkg.sv */
/*
 Package for the LVDS output power and start-up block: register offsets, field positions,
 reset values and timing constants shared by the device end, the controller end and the link.
 Assumes a single 10 MHz clock (hclk) serving as the sampling clock in this model.
*/
package lpi_pkg;
  // ==========================================================
  // Device register map (byte-wide registers on the link)
  localparam logic [11:0] reg_divider_ctrl = 12'h590;
  localparam logic [11:0] reg_lane_pd_high = 12'h691;
  localparam logic [11:0] reg_lane_pd_low = 12'h692;
  localparam logic [11:0] reg_cfg_status = 12'h025;
  localparam int divider_enable_bit = 1;
  localparam int bit_clock_pd_bit = 4;
  localparam int cfg_ready_bit = 4;
  localparam int lane_count = 8;
  localparam logic [7:0] lane_pd_reset = 8'h00;
  localparam logic [7:0] divider_ctrl_reset = 8'h00;
  localparam logic [7:0] divider_ctrl_mask = 8'h02;
  localparam logic [7:0] lane_pd_high_mask = 8'hf0;
  localparam logic [7:0] lane_pd_low_mask = 8'h1f;
  // ==========================================================
  // Timing
  localparam int clk_period_ns = 100;
  localparam int fuse_load_max_cycles = 10000;
  localparam int full_perf_cycles = 5000000;
  localparam int power_on_delay_us = 1;
  localparam int reset_pulse_ns = 100;
  localparam int power_on_cycles = (power_on_delay_us * 1000 + clk_period_ns - 1) / clk_period_ns;
  localparam int reset_pulse_cycles_raw = (reset_pulse_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int reset_pulse_cycles = (reset_pulse_cycles_raw < 1) ? 1 : reset_pulse_cycles_raw;
  // ==========================================================
  // Controller AHB-Lite register map
  localparam logic [7:0] ahb_ctrl = 8'h00;
  localparam logic [7:0] ahb_status = 8'h04;
  localparam logic [7:0] ahb_irq_status = 8'h08;
  localparam logic [7:0] ahb_irq_mask = 8'h0c;
  localparam logic [7:0] ahb_cmd = 8'h10;
  localparam logic [7:0] ahb_rdata = 8'h14;
  localparam int ctrl_start_bit = 0;
  localparam int cmd_write_bit = 31;
  localparam int cmd_addr_lsb = 8;
  localparam int irq_ready_bit = 0;
  localparam int irq_done_bit = 1;
  localparam int irq_perf_bit = 2;
  localparam int irq_width = 3;
  localparam logic [1:0] htrans_nonseq = 2'h2;
endpackage

/* rtl/lpi_link_if.sv */
/*
 Link between the controller and the device end: power-up reset strobe, a simple
 byte register port standing in for the serial port, and the lane and clock outputs.
 Assumes both ends run on the same clock.
*/
interface lpi_link_if;
  logic dev_reset;
  logic reg_req;
  logic reg_write;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_ack;
  logic [7:0] lane_data;
  logic [7:0] lane_oe;
  logic output_bit_clock;
  logic bit_clock_oe;
  logic data_rated;
  modport device (input dev_reset, reg_req, reg_write, reg_addr, reg_wdata,
    output reg_rdata, reg_ack, lane_data, lane_oe, output_bit_clock, bit_clock_oe, data_rated);
  modport host (output dev_reset, reg_req, reg_write, reg_addr, reg_wdata,
    input reg_rdata, reg_ack, lane_data, lane_oe, output_bit_clock, bit_clock_oe, data_rated);
endinterface

/* rtl/lpi_fuse_loader.sv */
/*
 Fuse load sequencer: after the device reset falls, counts the load time and then
 raises ready. Assumes the clock runs during and after the reset pulse.
*/
module lpi_fuse_loader #(
  parameter int load_cycles = lpi_pkg::fuse_load_max_cycles - 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic dev_reset,
  output logic load_busy,
  output logic ready
);
  typedef struct packed {
    logic [13:0] cnt;
    logic busy;
    logic rdy;
  } lpi_fl_state_t;
  lpi_fl_state_t r, next_r;

  always_comb begin
    next_r = r;
    if (dev_reset) begin
      next_r.cnt = '0;
      next_r.busy = 1'b1;
      next_r.rdy = 1'b0;
    end else if (r.busy) begin
      next_r.cnt = r.cnt + 14'h0001;
      if (r.cnt == 14'(load_cycles - 1)) begin // [R11]
        next_r.busy = 1'b0;
        next_r.rdy = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{cnt: 14'h0000, busy: 1'b1, rdy: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign load_busy = r.busy;
  assign ready = r.rdy;
endmodule

/* rtl/lpi_device.sv */
/*
 Device end: holds the divider control and lane power-down registers, runs the
 fuse load after reset, and drives the eight lanes and the output bit clock.
 Assumes the controller issues the reset pulse and waits for the ready flag.
*/
// Notes on behaviour
// R1: Divider enable bit halves the output bit clock
// R2: Lane power-down bit 1 powers lane down
// R3: Powered-down lane outputs float high impedance
// R4: Lanes 5-7 bits 7-5, lanes 0-4 bits 4-0
// R5: Bit 4 powers down the output bit clock
// R6: Controller pulses reset high after power-up
// R7: Controller waits 1 us before reset
// R8: Reset pulse lasts at least 100 ns
// R9: Clock runs before reset is applied
// R10: Defaults load from fuses on reset release
// R11: Ready flag set within 10k cycles
// R12: Controller programs only after ready seen
// R13: Data rated only after 5M cycles
// R14: Divider enable resets to zero
module lpi_device #(
  parameter int perf_cycles = lpi_pkg::full_perf_cycles
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link
  lpi_link_if.device link,
  // Sample data to be sent
  input wire logic [7:0] sample_data
);
  typedef struct packed {
    logic [7:0] div_ctrl;
    logic [7:0] pd_high;
    logic [7:0] pd_low;
    logic [7:0] rdata;
    logic ack;
    logic [7:0] lane_data;
    logic [7:0] lane_oe;
    logic bclk;
    logic bclk_oe;
    logic div_phase;
    logic [22:0] perf_cnt;
    logic rated;
  } lpi_dev_state_t;
  lpi_dev_state_t r, next_r;
  logic load_busy;
  logic ready;
  logic [7:0] lane_pd;

  lpi_fuse_loader u_loader (
    .hclk(hclk),
    .hresetn(hresetn),
    .dev_reset(link.dev_reset),
    .load_busy(load_busy),
    .ready(ready)
  );

  // ==========================================================
  // Lane map: high reg bits 7,6,5 -> lanes 5,6,7; low reg bits 4..0 -> lanes 0..4
  always_comb begin
    lane_pd[5] = r.pd_high[7]; // [R4]
    lane_pd[6] = r.pd_high[6];
    lane_pd[7] = r.pd_high[5];
    for (int i = 0; i < 5; i++) begin
      lane_pd[i] = r.pd_low[4 - i];
    end
  end

  // ==========================================================
  // Register access and output stage
  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    if (link.dev_reset || load_busy) begin
      // Fuse defaults
      next_r.div_ctrl = lpi_pkg::divider_ctrl_reset; // [R10] [R14]
      next_r.pd_high = lpi_pkg::lane_pd_reset; // [R2] [R5]
      next_r.pd_low = lpi_pkg::lane_pd_reset;
    end
    if (link.dev_reset) begin
      next_r.perf_cnt = '0;
      next_r.rated = 1'b0;
    end else if (!r.rated) begin
      next_r.perf_cnt = r.perf_cnt + 23'h000001;
      if (r.perf_cnt == 23'(perf_cycles - 1)) begin
        next_r.rated = 1'b1; // [R13]
      end
    end
    if (link.reg_req && !r.ack && !link.dev_reset) begin
      next_r.ack = 1'b1;
      next_r.rdata = 8'h00;
      case (link.reg_addr)
        lpi_pkg::reg_divider_ctrl: begin
          if (link.reg_write && !load_busy) begin
            next_r.div_ctrl = link.reg_wdata & lpi_pkg::divider_ctrl_mask;
          end
          next_r.rdata = r.div_ctrl;
        end
        lpi_pkg::reg_lane_pd_high: begin
          if (link.reg_write && !load_busy) begin
            next_r.pd_high = link.reg_wdata & lpi_pkg::lane_pd_high_mask;
          end
          next_r.rdata = r.pd_high;
        end
        lpi_pkg::reg_lane_pd_low: begin
          if (link.reg_write && !load_busy) begin
            next_r.pd_low = link.reg_wdata & lpi_pkg::lane_pd_low_mask;
          end
          next_r.rdata = r.pd_low;
        end
        lpi_pkg::reg_cfg_status: begin
          next_r.rdata[lpi_pkg::cfg_ready_bit] = ready; // [R11]
        end
        default: begin
          next_r.rdata = 8'h00;
        end
      endcase
    end
    // Bit clock: full rate toggles each cycle, divided rate every second cycle
    next_r.div_phase = ~r.div_phase;
    if (!r.div_ctrl[lpi_pkg::divider_enable_bit] || r.div_phase) begin // [R1]
      next_r.bclk = ~r.bclk;
    end
    next_r.bclk_oe = ~r.pd_high[lpi_pkg::bit_clock_pd_bit]; // [R5]
    if (r.pd_high[lpi_pkg::bit_clock_pd_bit]) begin
      next_r.bclk = 1'b0;
    end
    next_r.lane_oe = ~lane_pd; // [R2] [R3]
    next_r.lane_data = sample_data & ~lane_pd;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.reg_rdata = r.rdata;
  assign link.reg_ack = r.ack;
  assign link.lane_data = r.lane_data;
  assign link.lane_oe = r.lane_oe;
  assign link.output_bit_clock = r.bclk;
  assign link.bit_clock_oe = r.bclk_oe;
  assign link.data_rated = r.rated;
endmodule

/* rtl/lpi_host.sv */
/*
 Controller end: AHB-Lite slave registers; runs the power-up sequence (delay, reset
 pulse, poll ready) and then forwards single register commands to the device.
 Assumes hclk also clocks the device end.
*/
// Decided for this implementation: the AHB-Lite slave port.
module lpi_host (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic hready,
  // Interrupt
  output logic irq,
  // Link
  lpi_link_if.host link
);
  localparam int irq_w = lpi_pkg::irq_width;
  typedef enum logic [5:0] {
    st_idle = 6'h01, st_pwr = 6'h02, st_rst = 6'h04,
    st_poll = 6'h08, st_ready = 6'h10, st_xfer = 6'h20
  } lpi_state_t;
  typedef struct packed {
    lpi_state_t st;
    logic [7:0] cnt;
    logic poll_pending;
    logic dph;
    logic dwr;
    logic [7:0] daddr;
    logic [31:0] hrdata;
    logic [irq_w - 1:0] irq_st;
    logic [irq_w - 1:0] irq_mask;
    logic irq;
    logic req;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rst;
    logic rated_q;
  } lpi_host_state_t;
  lpi_host_state_t r, next_r;
  logic [irq_w - 1:0] ev;
  logic [31:0] rd_mux;

  always_comb begin
    next_r = r;
    ev = '0;
    rd_mux = 32'h00000000;
    next_r.rated_q = link.data_rated;
    // ==========================================================
    // Start-up and command sequencer
    case (r.st)
      st_idle: begin
        next_r.cnt = '0;
      end
      st_pwr: begin
        next_r.cnt = r.cnt + 8'h01;
        if (r.cnt == 8'(lpi_pkg::power_on_cycles - 1)) begin // [R7]
          next_r.st = st_rst;
          next_r.rst = 1'b1; // [R6] [R9]
          next_r.cnt = '0;
        end
      end
      st_rst: begin
        next_r.cnt = r.cnt + 8'h01;
        if (r.cnt == 8'(lpi_pkg::reset_pulse_cycles - 1)) begin // [R8]
          next_r.rst = 1'b0;
          next_r.st = st_poll;
        end
      end
      st_poll: begin
        if (!r.req) begin
          next_r.req = 1'b1;
          next_r.wr = 1'b0;
          next_r.addr = lpi_pkg::reg_cfg_status; // [R11]
        end else if (link.reg_ack) begin
          next_r.req = 1'b0;
          if (link.reg_rdata[lpi_pkg::cfg_ready_bit]) begin
            next_r.st = st_ready; // [R12]
            ev[lpi_pkg::irq_ready_bit] = 1'b1;
          end
        end
      end
      st_ready: begin
        if (r.poll_pending) begin
          next_r.req = 1'b1;
          next_r.poll_pending = 1'b0;
          next_r.st = st_xfer;
        end
      end
      st_xfer: begin
        if (link.reg_ack) begin
          next_r.req = 1'b0;
          next_r.rdata = link.reg_rdata;
          next_r.st = st_ready;
          ev[lpi_pkg::irq_done_bit] = 1'b1;
        end
      end
      default: begin
        next_r.st = st_idle;
      end
    endcase
    if (link.data_rated && !r.rated_q) begin
      ev[lpi_pkg::irq_perf_bit] = 1'b1;
    end
    // ==========================================================
    // AHB-Lite slave, zero wait state
    next_r.dph = hsel && hready && (htrans == lpi_pkg::htrans_nonseq);
    next_r.dwr = hwrite;
    next_r.daddr = haddr[7:0];
    // Read data is registered in the address phase so it stands in the data phase
    case (haddr[7:0])
      lpi_pkg::ahb_status: rd_mux = {26'h0, r.st};
      lpi_pkg::ahb_irq_status: rd_mux = {29'h0, r.irq_st};
      lpi_pkg::ahb_irq_mask: rd_mux = {29'h0, r.irq_mask};
      lpi_pkg::ahb_cmd: rd_mux = {19'h0, r.wr, r.addr};
      lpi_pkg::ahb_rdata: rd_mux = {24'h0, r.rdata};
      default: rd_mux = 32'h00000000;
    endcase
    next_r.irq_st = r.irq_st | ev;
    if (next_r.dph && !hwrite) begin
      next_r.hrdata = rd_mux;
    end
    if (r.dph && r.dwr) begin
      case (r.daddr)
        lpi_pkg::ahb_ctrl: begin
          if (hwdata[lpi_pkg::ctrl_start_bit] && r.st == st_idle) begin
            next_r.st = st_pwr;
            next_r.cnt = '0;
          end
        end
        lpi_pkg::ahb_irq_status: begin
          next_r.irq_st = (r.irq_st & ~hwdata[irq_w - 1:0]) | ev;
        end
        lpi_pkg::ahb_irq_mask: begin
          next_r.irq_mask = hwdata[irq_w - 1:0];
        end
        lpi_pkg::ahb_cmd: begin
          if (r.st == st_ready) begin // [R12]
            next_r.wr = hwdata[lpi_pkg::cmd_write_bit];
            next_r.addr = hwdata[lpi_pkg::cmd_addr_lsb +: 12];
            next_r.wdata = hwdata[7:0];
            next_r.poll_pending = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    next_r.irq = |(next_r.irq_st & next_r.irq_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{st: st_idle, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = r.irq;
  assign link.dev_reset = r.rst;
  assign link.reg_req = r.req;
  assign link.reg_write = r.wr;
  assign link.reg_addr = r.addr;
  assign link.reg_wdata = r.wdata;
endmodule

/* bench/lpi_link_checker.sv */
/*
 Checker of the link between the controller end and the device end.
 Assumes the bench instantiates it beside the link interface, on the one clock.
*/
module lpi_link_checker #(
  parameter int perf_cycles = 100
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link
  input wire logic dev_reset,
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic [7:0] lane_data,
  input wire logic [7:0] lane_oe,
  input wire logic output_bit_clock,
  input wire logic bit_clock_oe,
  input wire logic data_rated
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Helper state
  logic [15:0] since_rst;
  logic [15:0] since_load;
  logic pulsed;
  logic rdy_seen;
  logic clk_d1;
  logic clk_d2;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_rst <= 16'h0000;
      since_load <= 16'h0000;
      pulsed <= 1'b0;
      rdy_seen <= 1'b0;
      clk_d1 <= 1'b0;
      clk_d2 <= 1'b0;
    end else begin
      if (since_rst != 16'hffff) since_rst <= since_rst + 16'h0001;
      if (dev_reset) since_load <= 16'h0000;
      else if (since_load != 16'hffff) since_load <= since_load + 16'h0001;
      if (dev_reset) pulsed <= 1'b1;
      if (dev_reset) rdy_seen <= 1'b0;
      else if (reg_ack && !reg_write && reg_addr == lpi_pkg::reg_cfg_status &&
               reg_rdata[lpi_pkg::cfg_ready_bit]) rdy_seen <= 1'b1;
      clk_d1 <= output_bit_clock;
      clk_d2 <= clk_d1;
    end
  end
  // ==========================================================
  // Properties
  sequence s_req_open;
    reg_req && !reg_ack;
  endsequence
  sequence s_ack_then_drop;
    ##1 reg_ack ##1 (!reg_ack && !reg_req);
  endsequence
  property p_handshake;
    s_req_open |-> s_ack_then_drop;
  endproperty
  a_handshake: assert property (p_handshake) else $error("link handshake broken");
  property p_req_hold;
    s_req_open |=> $stable({reg_write, reg_addr, reg_wdata});
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed early");
  property p_lane_float;
    (lane_data & ~lane_oe) == 8'h00;
  endproperty
  a_lane_float: assert property (p_lane_float) else $error("idle lane drives data");
  property p_clk_off;
    !bit_clock_oe |-> !output_bit_clock;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("bit clock runs while off");
  property p_clk_runs;
    bit_clock_oe [*3] |-> !(output_bit_clock == clk_d1 && clk_d1 == clk_d2);
  endproperty
  a_clk_runs: assert property (p_clk_runs) else $error("bit clock stalled");
  property p_rst_pulse;
    $rose(dev_reset) |=> !dev_reset;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse length wrong");
  property p_rst_delay;
    dev_reset |-> since_rst >= 16'(lpi_pkg::power_on_cycles);
  endproperty
  a_rst_delay: assert property (p_rst_delay) else $error("reset pulse too early");
  property p_prog_after_rdy;
    reg_req && reg_write |-> rdy_seen;
  endproperty
  a_prog_after_rdy: assert property (p_prog_after_rdy) else $error("write before ready");
  property p_rated_late;
    pulsed && data_rated |-> since_load >= 16'(perf_cycles - 2);
  endproperty
  a_rated_late: assert property (p_rated_late) else $error("data rated too soon");
  property p_rated_on;
    pulsed && since_load >= 16'(perf_cycles + 2) |-> data_rated;
  endproperty
  a_rated_on: assert property (p_rated_on) else $error("data never rated");
endmodule

/* bench/tb_top.sv */
/*
 Bench: controller and device ends joined by the link, driven over AHB-Lite.
 Assumes one 10 MHz clock for both ends; the fuse load keeps its full length.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int load_cyc = lpi_pkg::fuse_load_max_cycles - 1;
  localparam int perf = 100;
  localparam int limit = 60000;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, irq, mon_chk, irq_on;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd_v;
  logic [7:0] sample_data, hi, lo, eoe;
  int error_cnt, checks, cyc, n, t;
  int seed = 79;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  string nm_q[$];
  lpi_link_if lnk ();
  always #50 hclk = ~hclk;
  lpi_host i_lpi_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hready(hreadyout), .irq(irq), .link(lnk.host));
  lpi_device #(.perf_cycles(perf)) i_lpi_device (.hclk(hclk), .hresetn(hresetn),
    .link(lnk.device), .sample_data(sample_data));
  lpi_link_checker #(.perf_cycles(perf)) i_lpi_link_checker (.hclk(hclk), .hresetn(hresetn),
    .dev_reset(lnk.dev_reset), .reg_req(lnk.reg_req), .reg_write(lnk.reg_write),
    .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata),
    .reg_ack(lnk.reg_ack), .lane_data(lnk.lane_data), .lane_oe(lnk.lane_oe),
    .output_bit_clock(lnk.output_bit_clock), .bit_clock_oe(lnk.bit_clock_oe),
    .data_rated(lnk.data_rated));
  // ==========================================================
  // Comparison and verdict
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == limit) begin
      error_cnt++;
      conclude();
    end
  end
  // Watcher: compares each checked read with the oldest note
  always @(posedge hclk) begin
    if (mon_chk && hreadyout) check(nm_q.pop_front(), hrdata & msk_q.pop_front(), exp_q.pop_front());
  end
  // ==========================================================
  // Bus tasks
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic chk, input string nm, input logic [31:0] msk);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= lpi_pkg::htrans_nonseq;
    hsel <= 1'b1;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    mon_chk <= chk;
    if (chk) begin
      exp_q.push_back(d & msk);
      msk_q.push_back(msk);
      nm_q.push_back(nm);
    end
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    rd_v = hrdata;
    mon_chk <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0, "", 32'h0);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, e, 1'b1, nm, m);
  endtask
  task automatic dev(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    wr(lpi_pkg::ahb_cmd, {w, 11'h000, a, d});
    k = 0;
    rd_v = 32'h0;
    while (rd_v[lpi_pkg::irq_done_bit] !== 1'b1 && k < 50) begin
      xfer(1'b0, lpi_pkg::ahb_irq_status, 32'h0, 1'b0, "", 32'h0);
      k++;
    end
    check("cmd_done", rd_v[lpi_pkg::irq_done_bit], 1'b1);
    check("irq_on_done", irq, irq_on);
    wr(lpi_pkg::ahb_irq_status, 32'h2);
  endtask
  task automatic dr(input string nm, input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    dev(1'b0, a, 8'h00);
    rd(nm, lpi_pkg::ahb_rdata, {24'h0, e}, {24'h0, m});
  endtask
  task automatic tog(output int c);
    logic p;
    c = 0;
    p = lnk.output_bit_clock;
    repeat (20) begin
      @(posedge hclk);
      if (lnk.output_bit_clock !== p) c++;
      p = lnk.output_bit_clock;
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, mon_chk, irq_on} = 5'h00;
    {haddr, hwdata, htrans, sample_data} = '0;
    hsize = 3'h2;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("irq_rest", irq, 1'b0);
    check("hresp_okay", hresp, 1'b0);
    check("hreadyout_on", hreadyout, 1'b1);
    wr(lpi_pkg::ahb_irq_mask, 32'h1);
    wr(lpi_pkg::ahb_ctrl, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < limit) begin
      @(posedge hclk);
      n++;
    end
    check("ready_time", n >= load_cyc && n < lpi_pkg::fuse_load_max_cycles + 40, 1'b1);
    rd("ready_flag", lpi_pkg::ahb_irq_status, 32'h1, 32'h1);
    wr(lpi_pkg::ahb_irq_status, 32'h1);
    rd("ready_clear", lpi_pkg::ahb_irq_status, 32'h0, 32'h1);
    check("irq_cleared", irq, 1'b0);
    dr("cfg_ready", lpi_pkg::reg_cfg_status, 8'h10, 8'h10);
    dr("div_rst", lpi_pkg::reg_divider_ctrl, 8'h00, 8'hff);
    dr("pd_hi_rst", lpi_pkg::reg_lane_pd_high, 8'h00, 8'hff);
    dr("pd_lo_rst", lpi_pkg::reg_lane_pd_low, 8'h00, 8'hff);
    check("lanes_on", lnk.lane_oe, 8'hff);
    check("bclk_on", lnk.bit_clock_oe, 1'b1);
    tog(t);
    check("bclk_full", t, 20);
    wr(lpi_pkg::ahb_irq_mask, 32'h2);
    irq_on = 1'b1;
    dev(1'b1, lpi_pkg::reg_divider_ctrl, 8'hff);
    dr("div_set", lpi_pkg::reg_divider_ctrl, 8'h02, 8'hff);
    tog(t);
    check("bclk_div", t, 10);
    wr(lpi_pkg::ahb_irq_mask, 32'h0);
    irq_on = 1'b0;
    for (int i = 0; i < 8; i++) begin
      hi = (i == 0) ? 8'hff : 8'($random(seed));
      lo = (i == 0) ? 8'hff : 8'($random(seed));
      sample_data <= 8'($random(seed));
      dev(1'b1, lpi_pkg::reg_lane_pd_high, hi);
      dev(1'b1, lpi_pkg::reg_lane_pd_low, lo);
      dr("pd_hi", lpi_pkg::reg_lane_pd_high, hi & 8'hf0, 8'hff);
      dr("pd_lo", lpi_pkg::reg_lane_pd_low, lo & 8'h1f, 8'hff);
      eoe = ~{hi[5], hi[6], hi[7], lo[0], lo[1], lo[2], lo[3], lo[4]};
      check("lane_oe", lnk.lane_oe, eoe);
      check("lane_data", lnk.lane_data, sample_data & eoe);
      check("bclk_oe", lnk.bit_clock_oe, !hi[4]);
    end
    dev(1'b1, 12'h123, 8'h5a);
    dr("dev_unmapped", 12'h123, 8'h00, 8'hff);
    wr(8'h20, 32'hffffffff);
    rd("ahb_unmapped", 8'h20, 32'h0, 32'hffffffff);
    check("rated", lnk.data_rated, 1'b1);
    rd("rated_irq", lpi_pkg::ahb_irq_status, 32'h4, 32'h4);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    check("lanes_after_rst", lnk.lane_oe, 8'hff);
    check("irq_after_rst", irq, 1'b0);
    conclude();
  end
endmodule
